// ===== logic/acs_sequencer.sv
// Converter sequencer with AHB-Lite register slave
// Behaviour
// - Ten-bit codes from one shared core
// - Sequencing runs on divided 1.33 MHz tick
// - Sixteen input channels selectable per slot
// - Out-of-range saturation comes from core
// - Settings apply from the next sequence; first delay, loop and freeze bits are read from ctrl while running
// - Done flag set; irq when unmasked
// - Calibrate at power-on before conversions
// - Core active while enabled or calibrating
// - Start bit begins a conversion series
// - Sync wait then first delay
// - Gap delay between consecutive conversions
// - Tail delay only in loop mode
// - All delay fields reset to zero
// - Delay is code times 40 us
// - At most eight conversions per pass
// - Each slot stores its own result
// - Pass runs slot zero to last slot
// - Loop mode repeats passes, resets off
// - Freeze stops result updates in loop
// - Results readable in four registers
// - Channels 12-15 as inputs without touch
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`include "acs_params.svh"

module acs_sequencer (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  core_done,
    input  wire acs_pkg::acs_code_type core_data,
    input  wire logic                  core_cal_done,
    input  wire logic                  touch_screen_on,
    output logic                       core_enable,
    output acs_pkg::acs_chan_type      core_channel,
    output logic                       core_start,
    output logic                       core_cal_start,
    output logic                       touch_gpio_sel,
    output logic                       irq_out
);
    import acs_pkg::*;

    acs_state_type state;
    logic [31:0]   ctrl;
    logic [31:0]   select_reg;
    logic          done_flag;
    logic          mask;
    logic          start_pend;
    logic          cal_issued;
    logic [7:0]    div_cnt;
    logic          tick;
    logic [9:0]    cnt;
    logic [2:0]    slot;
    logic [2:0]    run_last;
    logic [3:0]    run_gap;
    logic [3:0]    run_tail;
    logic [31:0]   run_sel;
    acs_code_type  result [8];
    logic          dp_wr;
    logic [7:0]    dp_addr;
    logic [31:0]   next_rdata;
    logic          addr_ok;
    logic          wr_ctrl;
    logic          wr_select;
    logic          wr_status;
    logic          wr_mask;
    logic          en;
    logic          loop_mode;
    logic          result_freeze;
    logic          take_cfg;
    logic          conv_end;
    logic          pass_end;
    acs_chan_type  cur_chan;
    logic [12:0]   sync_cycles;

    // Delay fields count in 40 us units of the slow tick
    function automatic logic [9:0] dly_ticks(input logic [3:0] code);
        dly_ticks = 10'(code) * 10'(`ACS_DLY_TICKS);
    endfunction : dly_ticks

    assign addr_ok   = hsel & hready & htrans[1] & (hsize == 3'h2);
    assign wr_ctrl   = dp_wr & (dp_addr == `ACS_OFS_CTRL);
    assign wr_select = dp_wr & (dp_addr == `ACS_OFS_SELECT);
    assign wr_status = dp_wr & (dp_addr == `ACS_OFS_STATUS);
    assign wr_mask   = dp_wr & (dp_addr == `ACS_OFS_MASK);

    assign en            = ctrl[`ACS_CTRL_EN];
    assign loop_mode     = ctrl[`ACS_CTRL_LOOP];
    assign result_freeze = ctrl[`ACS_CTRL_FREEZE];
    assign cur_chan      = run_sel[{slot, 2'h0} +: 4];
    assign conv_end      = (state == ST_CONV) & en & core_done;
    assign pass_end      = conv_end & (slot == run_last);
    assign take_cfg      = ((state == ST_IDLE) & start_pend & en)
                         | (pass_end & loop_mode);

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr     <= 1'b0;
            dp_addr   <= 8'h00;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            dp_wr     <= addr_ok & hwrite;
            dp_addr   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Unmapped offsets read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            `ACS_OFS_CTRL:    next_rdata = ctrl;
            `ACS_OFS_SELECT:  next_rdata = select_reg;
            `ACS_OFS_STATUS:  next_rdata = {21'h0, slot, 2'h0,
                                            state != ST_CAL,
                                            (state != ST_IDLE) &
                                            (state != ST_CAL),
                                            3'h0, done_flag};
            `ACS_OFS_MASK:    next_rdata = {31'h0, mask};
            `ACS_OFS_RESULT0: next_rdata = {6'h0, result[1],
                                            6'h0, result[0]};
            `ACS_OFS_RESULT1: next_rdata = {6'h0, result[3],
                                            6'h0, result[2]};
            `ACS_OFS_RESULT2: next_rdata = {6'h0, result[5],
                                            6'h0, result[4]};
            `ACS_OFS_RESULT3: next_rdata = {6'h0, result[7],
                                            6'h0, result[6]};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok & ~hwrite)
            hrdata <= next_rdata;
        else
            hrdata <= 32'h0000_0000;
    end

    // Start bit is not stored; it reads back zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= `ACS_CTRL_RST;
        else if (wr_ctrl)
            ctrl <= {12'h0, hwdata[19:8], 1'h0, hwdata[6:4],
                     hwdata[3:2], 1'b0, hwdata[0]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            select_reg <= `ACS_SELECT_RST;
        else if (wr_select)
            select_reg <= hwdata;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask <= `ACS_MASK_RST;
        else if (wr_mask)
            mask <= hwdata[0];
    end

    // A pass ending in the clearing cycle keeps the flag set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            done_flag <= 1'b0;
        else if (pass_end)
            done_flag <= 1'b1;
        else if (wr_status & hwdata[0])
            done_flag <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_out <= 1'b0;
        else
            irq_out <= done_flag & ~mask;
    end

    // Start requests wait for calibration to finish
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            start_pend <= 1'b0;
        else if (wr_ctrl & hwdata[`ACS_CTRL_START] & hwdata[`ACS_CTRL_EN])
            start_pend <= 1'b1;
        else if (!en | ((state == ST_IDLE) & start_pend))
            start_pend <= 1'b0;
    end

    // Slow tick for the sync and delay counters of the sequencing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt <= 8'h00;
            tick    <= 1'b0;
        end
        else if (div_cnt == 8'(`ACS_DIV_CYCLES - 1))
        begin
            div_cnt <= 8'h00;
            tick    <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 8'h01;
            tick    <= 1'b0;
        end
    end

    // Slot count, gap, tail and selection are frozen per pass so host writes never tear them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_last <= 3'h0;
            run_gap  <= 4'h0;
            run_tail <= 4'h0;
            run_sel  <= 32'h0000_0000;
        end
        else if (take_cfg)
        begin
            run_last <= ctrl[`ACS_CTRL_LAST +: 3];
            run_gap  <= ctrl[`ACS_CTRL_GDLY +: 4];
            run_tail <= ctrl[`ACS_CTRL_TDLY +: 4];
            run_sel  <= select_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_CAL;
            cnt   <= 10'h000;
            slot  <= 3'h0;
        end
        else
        begin
            unique case (state)
                ST_CAL:
                    if (core_cal_done)
                        state <= ST_IDLE;
                ST_IDLE:
                    if (start_pend & en)
                    begin
                        state <= ST_SYNC;
                        cnt   <= 10'(`ACS_SYNC_TICKS);
                        slot  <= 3'h0;
                    end
                ST_SYNC:
                    if (!en)
                        state <= ST_IDLE;
                    else if (tick)
                    begin
                        if (cnt == 10'h000)
                        begin
                            state <= ST_DELAY;
                            cnt   <= dly_ticks(ctrl[`ACS_CTRL_FDLY +: 4]);
                        end
                        else
                            cnt <= cnt - 10'h001;
                    end
                ST_DELAY:
                    if (!en)
                        state <= ST_IDLE;
                    else if (cnt == 10'h000)
                        state <= ST_CONV;
                    else if (tick)
                        cnt <= cnt - 10'h001;
                ST_CONV:
                    if (!en)
                        state <= ST_IDLE;
                    else if (pass_end & loop_mode)
                    begin
                        state <= ST_DELAY;
                        slot  <= 3'h0;
                        cnt   <= dly_ticks(run_tail);
                    end
                    else if (pass_end)
                        state <= ST_IDLE;
                    else if (conv_end)
                    begin
                        state <= ST_DELAY;
                        slot  <= slot + 3'h1;
                        cnt   <= dly_ticks(run_gap);
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Saturation of out-of-range inputs happens inside the core
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 8; i++)
                result[i] <= 10'h000;
        end
        else if (conv_end & ~(loop_mode & result_freeze))
            result[slot] <= core_data;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            core_start     <= 1'b0;
            core_channel   <= 4'h0;
            touch_gpio_sel <= 1'b0;
            core_enable    <= 1'b0;
        end
        else
        begin
            core_start     <= (state == ST_DELAY) & en & (cnt == 10'h000);
            core_channel   <= cur_chan;
            touch_gpio_sel <= ~touch_screen_on & (cur_chan >= 4'hC);
            core_enable    <= en | (state == ST_CAL);
        end
    end

    // One calibration request after power-on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cal_issued     <= 1'b0;
            core_cal_start <= 1'b0;
        end
        else
        begin
            cal_issued     <= 1'b1;
            core_cal_start <= ~cal_issued;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sync_cycles <= 13'h0000;
        else if (state == ST_SYNC)
            sync_cycles <= sync_cycles + 13'h0001;
        else
            sync_cycles <= 13'h0000;
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_irq_masked: assert property (mask && $past(mask) |-> !irq_out)
        else $error("irq raised while masked");
    a_done_set: assert property (pass_end |=> done_flag)
        else $error("done flag missing after pass");
    a_abort_idle: assert property ($fell(en) && state != ST_CAL |=>
                                   state == ST_IDLE && !done_flag ||
                                   $past(done_flag))
        else $error("disable did not abort");
    a_cal_first: assert property (core_start |-> state != ST_CAL &&
                                  $past(state) != ST_CAL)
        else $error("conversion before calibration");
    a_off_no_conv: assert property (!core_enable |-> !core_start)
        else $error("conversion while disabled");
    a_sync_bound: assert property (sync_cycles <=
                                   13'((`ACS_SYNC_TICKS + 2) *
                                   `ACS_DIV_CYCLES))
        else $error("sync wait too long");
    a_gap_zero: assert property (conv_end && !pass_end && run_gap == 4'h0
                                 ##1 en |=> core_start)
        else $error("zero gap not immediate");
    a_freeze_hold: assert property (conv_end && loop_mode && result_freeze
                                    |=> result[$past(slot)] ==
                                    $past(result[slot]))
        else $error("result updated while frozen");
    a_single_stop: assert property (pass_end && !loop_mode |=>
                                    state == ST_IDLE)
        else $error("single pass did not stop");
    a_start_slot0: assert property (state == ST_IDLE ##1 state == ST_SYNC
                                    |-> slot == 3'h0)
        else $error("pass not at slot zero");

endmodule : acs_sequencer

// ===== pkg/acs_params.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_OFS_CTRL     8'h00
`define ACS_OFS_SELECT   8'h04
`define ACS_OFS_STATUS   8'h08
`define ACS_OFS_MASK     8'h0C
`define ACS_OFS_RESULT0  8'h10
`define ACS_OFS_RESULT1  8'h14
`define ACS_OFS_RESULT2  8'h18
`define ACS_OFS_RESULT3  8'h1C

`define ACS_CTRL_EN      0
`define ACS_CTRL_START   1
`define ACS_CTRL_LOOP    2
`define ACS_CTRL_FREEZE  3
`define ACS_CTRL_LAST    4
`define ACS_CTRL_FDLY    8
`define ACS_CTRL_GDLY    12
`define ACS_CTRL_TDLY    16

`define ACS_CTRL_RST     32'h0000_0000
`define ACS_SELECT_RST   32'h7654_3210
`define ACS_MASK_RST     1'b1

`define ACS_CLK_HZ       200000000
`define ACS_TICK_HZ      1330000
`define ACS_DIV_CYCLES   (`ACS_CLK_HZ / `ACS_TICK_HZ)
`define ACS_SYNC_US      30
`define ACS_SYNC_TICKS   ((`ACS_SYNC_US * `ACS_TICK_HZ) / 1000000)
`define ACS_DLY_US       40
`define ACS_DLY_TICKS    ((`ACS_DLY_US * `ACS_TICK_HZ + 999999) / 1000000)

`endif

// ===== pkg/acs_pkg.sv
// Types shared by the conversion sequencer
package acs_pkg;
    typedef enum logic [4:0] {
        ST_CAL   = 5'h01,
        ST_IDLE  = 5'h02,
        ST_SYNC  = 5'h04,
        ST_DELAY = 5'h08,
        ST_CONV  = 5'h10
    } acs_state_type;
    typedef logic [9:0] acs_code_type;
    typedef logic [3:0] acs_chan_type;
endpackage : acs_pkg

// ===== tb/acs_core_model.sv
// Behavioural converter core on the far side of the sequencer
module acs_core_model (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  core_enable,
    input  wire logic                  core_start,
    input  wire logic                  core_cal_start,
    input  wire acs_pkg::acs_chan_type core_channel,
    input  wire logic [9:0]            bias,
    output logic                       core_done,
    output acs_pkg::acs_code_type      core_data,
    output logic                       core_cal_done
);
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    int           conv_cnt;
    int           cal_cnt;
    acs_chan_type held_chan;
    acs_code_type idle_pat;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cal_cnt       <= 0;
            core_cal_done <= 1'b0;
        end
        else if (core_cal_start)
            cal_cnt <= 40;
        else if (cal_cnt != 0)
        begin
            cal_cnt       <= cal_cnt - 1;
            core_cal_done <= (cal_cnt == 1) | core_cal_done;
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conv_cnt  <= 0;
            held_chan <= 4'h0;
            core_done <= 1'b0;
            idle_pat  <= 10'h155;
        end
        else
        begin
            core_done <= (conv_cnt == 1) & core_enable;
            idle_pat  <= ~idle_pat;
            // A disabled core drops its conversion in flight
            if (!core_enable)
                conv_cnt <= 0;
            else if (core_start)
            begin
                conv_cnt  <= 12;
                held_chan <= core_channel;
            end
            else if (conv_cnt != 0)
                conv_cnt <= conv_cnt - 1;
        end
    end
    // Small bias keeps codes below full scale; junk outside done
    assign core_data = core_done ? {2'b10, held_chan, held_chan} + bias
                                 : idle_pat;
endmodule : acs_core_model

// ===== tb/tb.sv
// Self-checking bench for the conversion sequencer
`include "acs_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic         core_done, core_cal_done, touch_screen_on, core_enable;
    logic         core_start, core_cal_start, touch_gpio_sel, irq_out;
    acs_code_type core_data;
    acs_chan_type core_channel;
    logic [9:0]   bias;
    int           fail_count = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    int           start_q[$];
    int           done_q[$];
    assign hready = hreadyout;
    acs_sequencer u_acs_sequencer (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_done(core_done),
        .core_data(core_data), .core_cal_done(core_cal_done),
        .touch_screen_on(touch_screen_on), .core_enable(core_enable),
        .core_channel(core_channel), .core_start(core_start),
        .core_cal_start(core_cal_start), .touch_gpio_sel(touch_gpio_sel),
        .irq_out(irq_out));
    acs_core_model u_acs_core_model (.hclk(hclk), .hresetn(hresetn),
        .core_enable(core_enable), .core_start(core_start),
        .core_cal_start(core_cal_start), .core_channel(core_channel),
        .bias(bias), .core_done(core_done), .core_data(core_data),
        .core_cal_done(core_cal_done));
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic finish_test;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : check
    function automatic logic [9:0] code(input int ch, input int b);
        return {2'b10, 4'(ch), 4'(ch)} + 10'(b);
    endfunction : code
    function automatic logic [31:0] pair(input int lo, input int b);
        return {6'h00, code(lo + 1, b), 6'h00, code(lo, b)};
    endfunction : pair
    function automatic logic in_range(input int x, input int lo,
                                      input int hi);
        return x >= lo && x <= hi;
    endfunction : in_range
    // Master side: address held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        check("hresp", 0, hresp);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check($sformatf("reg_%h", a), e, r);
    endtask : rd_chk
    // Hangs end at the timeout in the monitor
    task automatic wait_flag;
        logic [31:0] r;
        do bus(1'b0, `ACS_OFS_STATUS, 32'h0, r); while (r[0] !== 1'b1);
    endtask : wait_flag
    always @(posedge hclk)
    begin
        cyc++;
        if (core_start)
            start_q.push_back(cyc);
        if (core_done)
        begin
            done_q.push_back(cyc);
            check("enable", 1, core_enable);
            check("gpio", core_channel >= 4'hC && !touch_screen_on,
                  touch_gpio_sel);
        end
        if (cyc == 98000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        logic [31:0] v;
        int          n;
        int          t0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        touch_screen_on = 1'b0;
        bias = 10'h000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(`ACS_OFS_CTRL, 32'h0000_0000);
        rd_chk(`ACS_OFS_SELECT, 32'h7654_3210);
        rd_chk(`ACS_OFS_MASK, 32'h0000_0001);
        rd_chk(8'h40, 32'h0000_0000);
        do bus(1'b0, `ACS_OFS_STATUS, 32'h0, v); while (v[5] !== 1'b1);
        check("idle_enable", 0, core_enable);
        hsize <= 3'b000;
        wr(`ACS_OFS_CTRL, 32'h0000_0001);
        hsize <= 3'b010;
        rd_chk(`ACS_OFS_CTRL, 32'h0000_0000);
        wr(`ACS_OFS_SELECT, 32'hFEDC_BA98);
        wr(`ACS_OFS_MASK, 32'h0);
        wr(`ACS_OFS_CTRL, 32'h0000_0073);
        t0 = cyc;
        wait_flag();
        check("convs", 8, start_q.size());
        check("sync", 1,
              in_range(start_q[0] - t0, 5700, 6020));
        for (int k = 0; k < 4; k++)
            rd_chk(`ACS_OFS_RESULT0 + 8'(4 * k),
                   pair(8 + 2 * k, 0));
        check("irq", 1, irq_out);
        wr(`ACS_OFS_STATUS, 32'h1);
        repeat (3) @(posedge hclk);
        check("irq_clear", 0, irq_out);
        start_q.delete();
        done_q.delete();
        wr(`ACS_OFS_CTRL, 32'h000F_1113);
        t0 = cyc;
        wait_flag();
        check("first", 1,
              in_range(start_q[0] - t0, 13800, 14300));
        check("gap", 1,
              in_range(start_q[1] - done_q[0], 7950, 8400));
        repeat (300) @(posedge hclk);
        check("one_pass", 2, start_q.size());
        wr(`ACS_OFS_STATUS, 32'h1);
        touch_screen_on <= 1'b1;
        wr(`ACS_OFS_MASK, 32'h1);
        wr(`ACS_OFS_SELECT, 32'h0000_0321);
        start_q.delete();
        done_q.delete();
        wr(`ACS_OFS_CTRL, 32'h0001_0027);
        wait_flag();
        check("irq_masked", 0, irq_out);
        rd_chk(`ACS_OFS_RESULT0, pair(1, 0));
        rd_chk(`ACS_OFS_RESULT1,
               {6'h00, code(11, 0), 6'h00, code(3, 0)});
        bias <= 10'h005;
        wr(`ACS_OFS_CTRL, 32'h0001_002D);
        while (done_q.size() < 6) @(posedge hclk);
        check("tail", 1,
              in_range(start_q[3] - done_q[2], 7950, 15000));
        rd_chk(`ACS_OFS_RESULT0, pair(1, 0));
        wr(`ACS_OFS_CTRL, 32'h0001_0025);
        while (done_q.size() < 9) @(posedge hclk);
        repeat (4) @(posedge hclk);
        rd_chk(`ACS_OFS_RESULT0, pair(1, 5));
        rd_chk(`ACS_OFS_RESULT1,
               {6'h00, code(11, 0), 6'h00, code(3, 5)});
        wr(`ACS_OFS_STATUS, 32'h1);
        n = start_q.size();
        while (start_q.size() == n) @(posedge hclk);
        wr(`ACS_OFS_CTRL, 32'h0);
        n = start_q.size();
        repeat (1000) @(posedge hclk);
        check("abort", n, start_q.size());
        check("off_enable", 0, core_enable);
        bus(1'b0, `ACS_OFS_STATUS, 32'h0, v);
        check("abort_flag", 0, v[0]);
        finish_test();
    end
endmodule : tb
